//--- core/fifo_flag_defines.svh
// Purpose: constants of the fifo flag and offset logic
// Assumes: a 8192 x 18 / 16384 x 9 organisation
// Notes: offsets are 14 bits wide, enough for the deepest setting
//
// Contract
// - offsets held internally; one of eight default pairs loaded at master reset
// - load select sampled in master reset; high picks parallel, low serial
// - offsets read back only through the parallel data output
// - offsets may be programmed or reprogrammed any time after master reset
// - timing select sampled in master reset; high synchronous, low asynchronous
// - synchronous almost-full changes only on write clock edges
// - synchronous almost-empty changes only on read clock edges
// - asynchronous almost-full falls on write edge, rises on read edge
// - asynchronous almost-empty follows the count on both write and read clock edges
// - standard mode flags follow the word count against n, D/2, D-m, D
// - fallthrough flags follow count against n+1, D/2+1, D+1-m, D+1
// - capacity doubles when both ports are nine bits wide
// - n governs almost-empty, m governs almost-full
`ifndef FIFO_FLAG_DEFINES_SVH
`define FIFO_FLAG_DEFINES_SVH

`define FFL_DATA_W 18
`define FFL_OFFSET_W 14
`define FFL_COUNT_W 16
// depth in words for each width setting
`define FFL_DEPTH_WIDE 16'h2000
`define FFL_DEPTH_NARROW 16'h4000
// default offsets indexed by {load select, sel0, sel1}
`define FFL_DEF_000 14'h007f
`define FFL_DEF_001 14'h01ff
`define FFL_DEF_010 14'h00ff
`define FFL_DEF_011 14'h003f
`define FFL_DEF_100 14'h03ff
`define FFL_DEF_101 14'h001f
`define FFL_DEF_110 14'h000f
`define FFL_DEF_111 14'h0007
// last word index of a parallel sequence, and last serial bit
`define FFL_LAST_WORD_WIDE 2'h1
`define FFL_LAST_WORD_NARROW 2'h3
`define FFL_LAST_SERIAL_BIT 5'h1b
`define FFL_BYTE_W 8

`endif

//--- core/fifo_flag_pkg.sv
// Purpose: types of the fifo flag and offset logic
// Assumes: nothing beyond the defines header
// Notes: none
package fifo_flag_pkg;
  typedef enum logic [0:0] {
    LOAD_SERIAL = 1'b0,
    LOAD_PARALLEL = 1'b1
  } loadMode_t;

  typedef enum logic [0:0] {
    TIMING_ASYNC = 1'b0,
    TIMING_SYNC = 1'b1
  } flagTiming_t;
endpackage

//--- core/offset_program_unit.sv
// Purpose: offset registers with serial, parallel loading and parallel read-back
// Assumes: ticks are one-cycle enables standing for clock edges of each side
// Notes: empty offset is loaded first, then full offset
`include "fifo_flag_defines.svh"

module offset_program_unit
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // configuration from master reset
  input wire logic masterActive,
  input wire logic [2:0] defaultIndex,
  input wire fifo_flag_pkg::loadMode_t loadMode,
  input wire logic narrowIn,
  input wire logic narrowOut,
  // programming, write side
  input wire logic writeTick,
  input wire logic programWrite,
  input wire logic [`FFL_DATA_W-1:0] programData,
  input wire logic serialEnable,
  input wire logic serialIn,
  // read-back, read side
  input wire logic readTick,
  input wire logic offsetRead,
  output logic [`FFL_DATA_W-1:0] offsetDataOut,
  // offsets
  output logic [`FFL_OFFSET_W-1:0] emptyOffset,
  output logic [`FFL_OFFSET_W-1:0] fullOffset
);
  import fifo_flag_pkg::*;

  logic [`FFL_OFFSET_W-1:0] next_emptyOffset;
  logic [`FFL_OFFSET_W-1:0] next_fullOffset;
  logic [1:0] writeWord;
  logic [1:0] next_writeWord;
  logic [1:0] readWord;
  logic [1:0] next_readWord;
  logic [4:0] serialBit;
  logic [4:0] next_serialBit;
  logic [`FFL_DATA_W-1:0] next_offsetDataOut;
  logic [`FFL_OFFSET_W-1:0] defaultOffset;
  logic [`FFL_OFFSET_W-1:0] pick;
  logic [1:0] lastIn;
  logic [1:0] lastOut;

  // default pair chosen at master reset
  always_comb
  begin
    case (defaultIndex)
      3'h0: defaultOffset = `FFL_DEF_000;
      3'h1: defaultOffset = `FFL_DEF_001;
      3'h2: defaultOffset = `FFL_DEF_010;
      3'h3: defaultOffset = `FFL_DEF_011;
      3'h4: defaultOffset = `FFL_DEF_100;
      3'h5: defaultOffset = `FFL_DEF_101;
      3'h6: defaultOffset = `FFL_DEF_110;
      default: defaultOffset = `FFL_DEF_111;
    endcase
  end

  // loading sequencers and offset updates
  always_comb
  begin
    lastIn = narrowIn ? `FFL_LAST_WORD_NARROW : `FFL_LAST_WORD_WIDE;
    lastOut = narrowOut ? `FFL_LAST_WORD_NARROW : `FFL_LAST_WORD_WIDE;
    next_emptyOffset = emptyOffset;
    next_fullOffset = fullOffset;
    next_writeWord = writeWord;
    next_readWord = readWord;
    next_serialBit = serialBit;
    next_offsetDataOut = offsetDataOut;
    pick = '0;
    if (masterActive)
    begin
      next_emptyOffset = defaultOffset;
      next_fullOffset = defaultOffset;
      next_writeWord = '0;
      next_readWord = '0;
      next_serialBit = '0;
      next_offsetDataOut = '0;
    end
    else
    begin
      // parallel load, one word per write edge
      if (writeTick && programWrite && loadMode == LOAD_PARALLEL)
      begin
        pick = narrowIn ? (writeWord[1] ? fullOffset : emptyOffset) :
          (writeWord[0] ? fullOffset : emptyOffset);
        if (narrowIn && !writeWord[0])
          pick[`FFL_BYTE_W-1:0] = programData[`FFL_BYTE_W-1:0];
        else if (narrowIn)
          pick[`FFL_OFFSET_W-1:`FFL_BYTE_W] =
            programData[`FFL_OFFSET_W-`FFL_BYTE_W-1:0];
        else
          pick = programData[`FFL_OFFSET_W-1:0];
        if (narrowIn ? writeWord[1] : writeWord[0])
          next_fullOffset = pick;
        else
          next_emptyOffset = pick;
        next_writeWord = (writeWord == lastIn) ? 2'h0 : writeWord + 2'h1;
      end
      // serial load, lsb first, empty then full
      if (writeTick && serialEnable && loadMode == LOAD_SERIAL)
      begin
        if (serialBit < 5'(`FFL_OFFSET_W))
          next_emptyOffset[serialBit[3:0]] = serialIn;
        else
          next_fullOffset[4'(serialBit - 5'(`FFL_OFFSET_W))] = serialIn;
        next_serialBit = (serialBit == `FFL_LAST_SERIAL_BIT) ? 5'h0 : serialBit + 5'h1;
      end
      // read-back through the parallel output only
      if (readTick && offsetRead)
      begin
        pick = (narrowOut ? readWord[1] : readWord[0]) ? fullOffset : emptyOffset;
        next_offsetDataOut = '0;
        if (narrowOut && !readWord[0])
          next_offsetDataOut[`FFL_BYTE_W-1:0] = pick[`FFL_BYTE_W-1:0];
        else if (narrowOut)
          next_offsetDataOut[`FFL_OFFSET_W-`FFL_BYTE_W-1:0] =
            pick[`FFL_OFFSET_W-1:`FFL_BYTE_W];
        else
          next_offsetDataOut[`FFL_OFFSET_W-1:0] = pick;
        next_readWord = (readWord == lastOut) ? 2'h0 : readWord + 2'h1;
      end
    end
  end

  // offset and sequencer registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      emptyOffset <= `FFL_DEF_000;
      fullOffset <= `FFL_DEF_000;
      writeWord <= 2'h0;
      readWord <= 2'h0;
      serialBit <= 5'h0;
      offsetDataOut <= '0;
    end
    else
    begin
      emptyOffset <= next_emptyOffset;
      fullOffset <= next_fullOffset;
      writeWord <= next_writeWord;
      readWord <= next_readWord;
      serialBit <= next_serialBit;
      offsetDataOut <= next_offsetDataOut;
    end
  end
endmodule // offset_program_unit

//--- core/fifo_programmable_flag_logic.sv
// Purpose: word count and status flags of a deep fifo, with offset programming
// Assumes: write and read clock edges arrive as one-cycle ticks on clk_sys
// Notes: all flags are active low; the unused mode's flags rest at fixed levels
`include "fifo_flag_defines.svh"

module fifo_programmable_flag_logic
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic arst_n,
  // master reset and straps sampled during it
  input wire logic masterResetIn_n,
  input wire logic offsetLoadSelect,
  input wire logic defaultSelect0,
  input wire logic defaultSelect1,
  input wire logic flagTimingSelect,
  input wire logic firstWordFallthrough,
  input wire logic inputWidthSelect,
  input wire logic outputWidthSelect,
  // write side
  input wire logic writeTick,
  input wire logic writeEnable,
  input wire logic programWrite,
  input wire logic [`FFL_DATA_W-1:0] programData,
  input wire logic serialEnable,
  input wire logic serialIn,
  // read side
  input wire logic readTick,
  input wire logic readEnable,
  input wire logic offsetRead,
  output logic [`FFL_DATA_W-1:0] offsetDataOut,
  // status flags
  output logic fullFlag_n,
  output logic inputReadyFlag_n,
  output logic almostFullFlag_n,
  output logic halfFullFlag_n,
  output logic almostEmptyFlag_n,
  output logic emptyFlag_n,
  output logic outputReadyFlag_n,
  output logic [`FFL_COUNT_W-1:0] wordCount
);
  import fifo_flag_pkg::*;

  // configuration captured during master reset
  loadMode_t loadMode;
  loadMode_t next_loadMode;
  flagTiming_t flagTiming;
  flagTiming_t next_flagTiming;
  logic fallThrough;
  logic next_fallThrough;
  logic narrowIn;
  logic next_narrowIn;
  logic narrowOut;
  logic next_narrowOut;
  logic [2:0] defaultIndex;
  logic [2:0] next_defaultIndex;
  logic masterActive;

  // count and flags
  logic [`FFL_COUNT_W-1:0] next_wordCount;
  logic next_fullFlag_n;
  logic next_inputReadyFlag_n;
  logic next_almostFullFlag_n;
  logic next_halfFullFlag_n;
  logic next_almostEmptyFlag_n;
  logic next_emptyFlag_n;
  logic next_outputReadyFlag_n;
  logic [`FFL_COUNT_W-1:0] depth;
  logic [`FFL_COUNT_W-1:0] capacity;
  logic [`FFL_COUNT_W-1:0] halfMark;
  logic [`FFL_COUNT_W-1:0] emptyMark;
  logic [`FFL_COUNT_W-1:0] fullMark;
  logic writeTaken;
  logic readTaken;
  logic nearFull;
  logic nearEmpty;
  logic [`FFL_OFFSET_W-1:0] emptyOffset;
  logic [`FFL_OFFSET_W-1:0] fullOffset;

  assign masterActive = !masterResetIn_n;

  // straps follow the pins while master reset is held
  always_comb
  begin
    next_loadMode = loadMode;
    next_flagTiming = flagTiming;
    next_fallThrough = fallThrough;
    next_narrowIn = narrowIn;
    next_narrowOut = narrowOut;
    next_defaultIndex = defaultIndex;
    if (masterActive)
    begin
      next_loadMode = loadMode_t'(offsetLoadSelect);
      next_flagTiming = flagTiming_t'(flagTimingSelect);
      next_fallThrough = firstWordFallthrough;
      next_narrowIn = inputWidthSelect;
      next_narrowOut = outputWidthSelect;
      next_defaultIndex = {offsetLoadSelect, defaultSelect0, defaultSelect1};
    end
  end

  // strap registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      loadMode <= LOAD_SERIAL;
      flagTiming <= TIMING_ASYNC;
      fallThrough <= 1'b0;
      narrowIn <= 1'b0;
      narrowOut <= 1'b0;
      defaultIndex <= 3'h0;
    end
    else
    begin
      loadMode <= next_loadMode;
      flagTiming <= next_flagTiming;
      fallThrough <= next_fallThrough;
      narrowIn <= next_narrowIn;
      narrowOut <= next_narrowOut;
      defaultIndex <= next_defaultIndex;
    end
  end

  offset_program_unit offsets
  (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .masterActive(masterActive),
    .defaultIndex(next_defaultIndex),
    .loadMode(loadMode),
    .narrowIn(narrowIn),
    .narrowOut(narrowOut),
    .writeTick(writeTick),
    .programWrite(programWrite),
    .programData(programData),
    .serialEnable(serialEnable),
    .serialIn(serialIn),
    .readTick(readTick),
    .offsetRead(offsetRead),
    .offsetDataOut(offsetDataOut),
    .emptyOffset(emptyOffset),
    .fullOffset(fullOffset)
  );

  // thresholds for the active mode
  always_comb
  begin
    depth = (narrowIn && narrowOut) ? `FFL_DEPTH_NARROW : `FFL_DEPTH_WIDE;
    capacity = depth + {15'h0, fallThrough}; // output word adds one in fallthrough
    halfMark = (depth >> 1) + {15'h0, fallThrough};
    emptyMark = {2'h0, emptyOffset} + {15'h0, fallThrough};
    fullMark = capacity - {2'h0, fullOffset};
  end

  // word count, writes and reads accepted at their own edges
  always_comb
  begin
    writeTaken = writeTick && writeEnable && !programWrite && wordCount != capacity;
    readTaken = readTick && readEnable && !offsetRead && wordCount != '0;
    next_wordCount = wordCount;
    if (masterActive)
      next_wordCount = '0;
    else if (writeTaken && !readTaken)
      next_wordCount = wordCount + 16'h1;
    else if (readTaken && !writeTaken)
      next_wordCount = wordCount - 16'h1;
  end

  // flag levels from the updated count
  always_comb
  begin
    nearFull = next_wordCount >= fullMark;
    nearEmpty = next_wordCount <= emptyMark;
    next_fullFlag_n = fallThrough || next_wordCount != capacity;
    next_inputReadyFlag_n = fallThrough && next_wordCount == capacity;
    next_emptyFlag_n = fallThrough || next_wordCount != '0;
    next_outputReadyFlag_n = !fallThrough || next_wordCount == '0;
    next_halfFullFlag_n = !(next_wordCount > halfMark);
    next_almostFullFlag_n = almostFullFlag_n;
    next_almostEmptyFlag_n = almostEmptyFlag_n;
    if (masterActive)
    begin
      next_almostFullFlag_n = 1'b1;
      next_almostEmptyFlag_n = 1'b0;
      next_fullFlag_n = 1'b1;
      next_inputReadyFlag_n = 1'b0;
      next_emptyFlag_n = 1'b0;
      next_outputReadyFlag_n = 1'b1;
      next_halfFullFlag_n = 1'b1;
    end
    else if (flagTiming == TIMING_SYNC)
    begin
      if (writeTick)
        next_almostFullFlag_n = !nearFull;
      if (readTick)
        next_almostEmptyFlag_n = !nearEmpty;
    end
    else
    begin
      if (writeTick && nearFull)
        next_almostFullFlag_n = 1'b0;
      else if (readTick && !nearFull)
        next_almostFullFlag_n = 1'b1;
      if (writeTick || readTick)
        next_almostEmptyFlag_n = !nearEmpty;
    end
  end

  // count and flag registers
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wordCount <= '0;
      fullFlag_n <= 1'b1;
      inputReadyFlag_n <= 1'b0;
      almostFullFlag_n <= 1'b1;
      halfFullFlag_n <= 1'b1;
      almostEmptyFlag_n <= 1'b0;
      emptyFlag_n <= 1'b0;
      outputReadyFlag_n <= 1'b1;
    end
    else
    begin
      wordCount <= next_wordCount;
      fullFlag_n <= next_fullFlag_n;
      inputReadyFlag_n <= next_inputReadyFlag_n;
      almostFullFlag_n <= next_almostFullFlag_n;
      halfFullFlag_n <= next_halfFullFlag_n;
      almostEmptyFlag_n <= next_almostEmptyFlag_n;
      emptyFlag_n <= next_emptyFlag_n;
      outputReadyFlag_n <= next_outputReadyFlag_n;
    end
  end
endmodule // fifo_programmable_flag_logic

//--- dv/fifo_flag_checker.sv
// Purpose: port checker of the fifo flag logic
// Assumes: straps are latched while master reset is low
// Notes: offsets are hidden, so almost flags are judged only for timing, empty, full and ready flags for level
`include "fifo_flag_defines.svh"

module fifo_flag_checker
(
  // clock and resets
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic masterResetIn_n,
  // straps
  input wire logic flagTimingSelect,
  input wire logic firstWordFallthrough,
  input wire logic inputWidthSelect,
  input wire logic outputWidthSelect,
  // requests
  input wire logic writeTick,
  input wire logic writeEnable,
  input wire logic programWrite,
  input wire logic readTick,
  input wire logic readEnable,
  input wire logic offsetRead,
  // answers
  input wire logic [`FFL_DATA_W-1:0] offsetDataOut,
  input wire logic fullFlag_n,
  input wire logic inputReadyFlag_n,
  input wire logic almostFullFlag_n,
  input wire logic almostEmptyFlag_n,
  input wire logic emptyFlag_n,
  input wire logic outputReadyFlag_n,
  input wire logic [`FFL_COUNT_W-1:0] wordCount
);
  timeunit 1ns;
  timeprecision 1ns;
  logic settled, syncMode, fallMode, narrow, wrTaken, rdTaken;
  logic [3:0] next_mode;
  logic [15:0] depth, cap;
  // strap image, refreshed only in master reset
  always_comb
  begin
    next_mode = {masterResetIn_n, syncMode, fallMode, narrow};
    if (!masterResetIn_n)
    begin
      next_mode[2:0] = {flagTimingSelect, firstWordFallthrough,
        inputWidthSelect & outputWidthSelect};
    end
  end
  // register strap image and settle mark
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      {settled, syncMode, fallMode, narrow} <= 4'h0;
    end
    else
    begin
      {settled, syncMode, fallMode, narrow} <= next_mode;
    end
  end
  // capacity and accepted transfers
  assign depth = narrow ? `FFL_DEPTH_NARROW : `FFL_DEPTH_WIDE;
  assign cap = fallMode ? depth + 16'h0001 : depth;
  assign wrTaken = writeTick && writeEnable && !programWrite && wordCount != cap;
  assign rdTaken = readTick && readEnable && !offsetRead && wordCount != 16'h0000;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n || !masterResetIn_n);

  a_empty_level: assert property
    (settled && !fallMode |-> emptyFlag_n == (wordCount != 16'h0000))
    else $error("empty flag off count");
  a_full_level: assert property
    (settled && !fallMode |-> fullFlag_n == (wordCount != depth))
    else $error("full flag off count");
  a_ready_level: assert property
    (settled && fallMode |->
      outputReadyFlag_n == (wordCount == 16'h0000) && inputReadyFlag_n == (wordCount == cap))
    else $error("ready flags off count");
  a_count_step: assert property
    (settled && wrTaken && !rdTaken |=> wordCount == $past(wordCount) + 16'h0001)
    else $error("write not counted");
  a_sync_full_edge: assert property
    (settled && syncMode && !writeTick |=> $stable(almostFullFlag_n))
    else $error("sync almost-full moved off write edge");
  a_sync_empty_edge: assert property
    (settled && syncMode && !readTick |=> $stable(almostEmptyFlag_n))
    else $error("sync almost-empty moved off read edge");
  a_async_fall: assert property
    (settled && !syncMode && $fell(almostFullFlag_n) |-> $past(writeTick))
    else $error("async almost-full fell off write edge");
  a_readback_hold: assert property
    (settled && !(readTick && offsetRead) |=> $stable(offsetDataOut))
    else $error("read-back word moved");

  c_full: cover property (settled && !fullFlag_n);
  c_ready: cover property (settled && fallMode && inputReadyFlag_n);
  c_offset: cover property (readTick && offsetRead);
endmodule // fifo_flag_checker

bind fifo_programmable_flag_logic fifo_flag_checker i_fifo_flag_checker
(
  .clk_sys, .arst_n, .masterResetIn_n, .flagTimingSelect, .firstWordFallthrough,
  .inputWidthSelect, .outputWidthSelect, .writeTick, .writeEnable, .programWrite,
  .readTick, .readEnable, .offsetRead, .offsetDataOut, .fullFlag_n, .inputReadyFlag_n,
  .almostFullFlag_n, .almostEmptyFlag_n, .emptyFlag_n, .outputReadyFlag_n, .wordCount
);

//--- dv/far_side_model.sv
// Purpose: writer and reader logic facing the fifo flag block
// Assumes: ticks stand for edges of the two outside clocks
// Notes: released data lines show the inverse of their last value
`include "fifo_flag_defines.svh"

module far_side_model
(
  // clock
  input wire logic clk_sys,
  // master reset and straps {load, sel0, sel1, timing, first_word_fallthrough, in x9, out x9}
  output logic masterResetIn_n,
  output logic [6:0] straps,
  // write side
  output logic writeTick, writeEnable, programWrite, serialEnable, serialIn,
  output logic [`FFL_DATA_W-1:0] programData,
  // read side
  output logic readTick, readEnable, offsetRead,
  input wire logic [`FFL_DATA_W-1:0] offsetDataOut
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle state, master reset asserted
  initial
  begin
    {masterResetIn_n, straps, writeTick, writeEnable, programWrite} = '0;
    {serialEnable, serialIn, programData, readTick, readEnable, offsetRead} = '0;
  end
  // master reset with straps held throughout
  task automatic master_reset(input logic [6:0] s);
  begin
    @(posedge clk_sys);
    straps <= s;
    masterResetIn_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    masterResetIn_n <= 1'b1;
    @(posedge clk_sys);
  end
  endtask
  // words or idle ticks on either side, prompt or slow
  task automatic xfer(input logic rd, input int cnt, input logic en, input logic slow);
  begin
    @(posedge clk_sys);
    for (int i = 0; i < cnt; i++)
    begin
      writeTick <= !rd;
      readTick <= rd;
      writeEnable <= en & !rd;
      readEnable <= en & rd;
      @(posedge clk_sys);
      if (slow)
      begin
        writeTick <= 1'b0;
        readTick <= 1'b0;
        @(posedge clk_sys);
      end
    end
    {writeTick, readTick, writeEnable, readEnable} <= 4'h0;
  end
  endtask
  // one parallel offset word
  task automatic prog_word(input logic [`FFL_DATA_W-1:0] d);
  begin
    @(posedge clk_sys);
    {programWrite, writeTick} <= 2'h3;
    programData <= d;
    @(posedge clk_sys);
    {programWrite, writeTick} <= 2'h0;
    programData <= ~d;
  end
  endtask
  // serial offsets, lsb first, empty then full
  task automatic serial_load(input logic [27:0] b);
  begin
    @(posedge clk_sys);
    {serialEnable, writeTick} <= 2'h3;
    for (int i = 0; i < 28; i++)
    begin
      serialIn <= b[i];
      @(posedge clk_sys);
    end
    {serialEnable, writeTick} <= 2'h0;
    serialIn <= ~b[27];
  end
  endtask
  // one read-back word, taken a cycle after the request
  task automatic read_offset(output logic [`FFL_DATA_W-1:0] d);
  begin
    @(posedge clk_sys);
    {offsetRead, readTick} <= 2'h3;
    @(posedge clk_sys);
    {offsetRead, readTick} <= 2'h0;
    #1;
    d = offsetDataOut;
  end
  endtask
endmodule // far_side_model

//--- dv/fifo_programmable_flag_logic_tb.sv
// Purpose: self-checking bench of the fifo flag logic
// Assumes: far side model drives every block input except clk_sys and arst_n
// Notes: long fills run at full depth in the 8192-word modes except sync, which stops at 8065, the 16384-word mode only to 8193; no shortened counts
`include "fifo_flag_defines.svh"

module fifo_programmable_flag_logic_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0;
  logic arst_n, masterResetIn_n, writeTick, writeEnable, programWrite;
  logic serialEnable, serialIn, readTick, readEnable, offsetRead;
  logic fullFlag_n, inputReadyFlag_n, almostFullFlag_n, halfFullFlag_n;
  logic almostEmptyFlag_n, emptyFlag_n, outputReadyFlag_n, fallMode;
  logic [6:0] straps;
  logic [`FFL_DATA_W-1:0] programData, offsetDataOut;
  logic [`FFL_COUNT_W-1:0] wordCount;
  logic [13:0] defs [8] = '{14'h007f, 14'h01ff, 14'h00ff, 14'h003f,
    14'h03ff, 14'h001f, 14'h000f, 14'h0007};
  int errCount = 0, checked = 0, cnt, n, m, d;

  always #5 clk_sys = ~clk_sys;

  fifo_programmable_flag_logic i_fifo_programmable_flag_logic
  (
    .clk_sys, .arst_n, .masterResetIn_n, .offsetLoadSelect(straps[6]),
    .defaultSelect0(straps[5]), .defaultSelect1(straps[4]), .flagTimingSelect(straps[3]),
    .firstWordFallthrough(straps[2]), .inputWidthSelect(straps[1]),
    .outputWidthSelect(straps[0]), .writeTick, .writeEnable, .programWrite, .programData,
    .serialEnable, .serialIn, .readTick, .readEnable, .offsetRead, .offsetDataOut,
    .fullFlag_n, .inputReadyFlag_n, .almostFullFlag_n, .halfFullFlag_n, .almostEmptyFlag_n,
    .emptyFlag_n, .outputReadyFlag_n, .wordCount
  );
  far_side_model i_far_side_model
  (
    .clk_sys, .masterResetIn_n, .straps, .writeTick, .writeEnable, .programWrite,
    .serialEnable, .serialIn, .programData, .readTick, .readEnable, .offsetRead,
    .offsetDataOut
  );
  // verdict and end of run
  task automatic report_and_stop;
  begin
    $display("checks %0d mismatches %0d", checked, errCount);
    if (errCount == 0 && checked > 0)
    begin
      $display("NO MISMATCHES");
    end
    else
    begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  end
  endtask
  // compare one word or bit
  task automatic check_word(input logic [17:0] got, input logic [17:0] exp);
  begin
    checked++;
    if (got !== exp)
    begin
      errCount++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  end
  endtask
  // compare flag set and count against cnt
  task automatic check_flags;
    logic [4:0] got, exp;
  begin
    #1;
    got = {fullFlag_n, almostFullFlag_n, halfFullFlag_n, almostEmptyFlag_n, emptyFlag_n};
    exp = {cnt != d, cnt < d - m, cnt <= d / 2, cnt > n, cnt != 0};
    if (fallMode)
    begin
      got = {inputReadyFlag_n, got[3:1], outputReadyFlag_n};
      exp = {cnt == d + 1, cnt < d + 1 - m, cnt <= d / 2 + 1, cnt > n + 1, cnt == 0};
    end
    checked++;
    if (got !== exp || wordCount !== 16'(cnt))
    begin
      errCount++;
      $display("[ERR] %0t at %0d flags %b want %b", $time, cnt, got, exp);
    end
  end
  endtask
  // move fill level to t, moves of one or two words paced slowly
  task automatic step(input int t);
    int k;
  begin
    k = t > cnt ? t - cnt : cnt - t;
    i_far_side_model.xfer(t < cnt, k, 1'b1, k < 3);
    cnt = t;
    check_flags();
  end
  endtask
  // master reset into a mode with default offsets 127
  task automatic start(input logic [6:0] s, input logic f, input int depth);
  begin
    i_far_side_model.master_reset(s);
    fallMode = f;
    cnt = 0;
    n = 127;
    m = 127;
    d = depth;
    check_flags();
  end
  endtask
  // all eight default pairs read back
  task automatic sc_defaults;
    logic [17:0] w;
  begin
    for (int i = 0; i < 8; i++)
    begin
      i_far_side_model.master_reset({3'(i), 4'h0});
      i_far_side_model.read_offset(w);
      check_word(w, {4'h0, defs[i]});
      i_far_side_model.read_offset(w);
      check_word(w, {4'h0, defs[i]});
    end
  end
  endtask
  // load offsets one way, read both back
  task automatic offs_case(input logic par, input int e, f, xe, xf);
    logic [17:0] w;
  begin
    if (par)
    begin
      i_far_side_model.prog_word(18'(e));
      i_far_side_model.prog_word(18'(f));
    end
    else
    begin
      i_far_side_model.serial_load({14'(f), 14'(e)});
    end
    i_far_side_model.read_offset(w);
    check_word(w, 18'(xe));
    i_far_side_model.read_offset(w);
    check_word(w, 18'(xf));
  end
  endtask
  // synchronous almost flags wait for their own side
  task automatic sc_sync;
  begin
    start(7'h08, 1'b0, 8192);
    i_far_side_model.xfer(1'b0, 128, 1'b1, 1'b0);
    cnt = 128;
    #1;
    check_word(almostEmptyFlag_n, 18'h0);
    i_far_side_model.xfer(1'b1, 1, 1'b0, 1'b1);
    check_flags();
    step(8065);
    i_far_side_model.xfer(1'b1, 1, 1'b1, 1'b1);
    cnt = 8064;
    #1;
    check_word(almostFullFlag_n, 18'h0);
    i_far_side_model.xfer(1'b0, 1, 1'b0, 1'b1);
    check_flags();
  end
  endtask
  // nine-bit ports: four bytes in, the same four bytes back
  task automatic sc_narrow;
    logic [17:0] w;
    logic [17:0] b [4];
  begin
    b = '{18'h0005c, 18'h0000a, 18'h00043, 18'h00021};
    i_far_side_model.master_reset(7'h43);
    foreach (b[i]) i_far_side_model.prog_word(b[i]);
    foreach (b[i])
    begin
      i_far_side_model.read_offset(w);
      check_word(w, b[i]);
    end
  end
  endtask
  // watchdog
  initial
  begin
    repeat (90000) @(posedge clk_sys);
    errCount++;
    $display("[ERR] %0t run too long", $time);
    report_and_stop();
  end
  // main sequence
  initial
  begin
    arst_n = 1'b0;
    repeat (3) @(posedge clk_sys);
    arst_n <= 1'b1;
    sc_defaults();
    i_far_side_model.master_reset(7'h40);
    offs_case(1'b1, 5, 9, 5, 9);
    offs_case(1'b1, 0, 8191, 0, 8191);
    offs_case(1'b0, 3, 4, 0, 8191);
    i_far_side_model.master_reset(7'h00);
    offs_case(1'b0, 100, 200, 100, 200);
    offs_case(1'b1, 3, 4, 100, 200);
    sc_narrow();
    start(7'h00, 1'b0, 8192);
    foreach (defs[i]) step(i % 2 == 0 ? 1 : 0);
    step(127);
    step(128);
    step(4096);
    step(4097);
    step(8064);
    step(8065);
    step(8192);
    i_far_side_model.xfer(1'b0, 1, 1'b1, 1'b0);
    check_flags();
    step(8191);
    step(8064);
    step(0);
    i_far_side_model.xfer(1'b1, 1, 1'b1, 1'b0);
    check_flags();
    sc_sync();
    start(7'h04, 1'b1, 8192);
    step(1);
    step(128);
    step(129);
    step(4098);
    step(8066);
    step(8193);
    i_far_side_model.xfer(1'b0, 1, 1'b1, 1'b0);
    check_flags();
    step(8192);
    start(7'h03, 1'b0, 16384);
    step(8192);
    step(8193);
    report_and_stop();
  end
endmodule // fifo_programmable_flag_logic_tb
